// ===== verilog/pwm_regs.svh
// register offsets, field positions, reset values and timing counts
// Operation
// - duty is ten bits: high byte plus two
// - timer clears on increment after period match
// - output set at period start unless duty zero
// - high duty bits copied to buffer at boundary
// - duty writes allowed anytime, used next period
// - duty buffer read-only while in pwm mode
// - time base: count plus clock phase/prescaler bits
// - output cleared when time base equals duty
// - two low duty bits latched at boundary
// - period is (limit+1) times 4 times prescale
// - postscaler ignored for pwm period
// - timer-select field picks one of three timers
// - prescale factors 1, 4 and 16
// - duty beyond period never clears output
// - full resolution only with limit 255
// - frozen state and output while asleep
// - reset restores registers, pin becomes input
// - timer flag set on each period match
// - cleared mode register releases the pin
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// block-level registers (byte addresses)
`define OFS_MODE_CTRL    8'h00
`define OFS_TIMER_SEL    8'h01
`define OFS_DUTY_HIGH    8'h02
`define OFS_DUTY_BUF     8'h03
`define OFS_PIN_DIR      8'h04
// period timers: base + 4 * timer index + register index
`define TMR_BASE_HI      4'h1
`define TMR_IDX_LIMIT    2'h0
`define TMR_IDX_CTRL     2'h1
`define TMR_IDX_COUNT    2'h2
`define TMR_IDX_FLAG     2'h3

// field positions
`define MODE_FIELD_HI    3
`define MODE_FIELD_LO    0
`define DUTY_LSB_HI      5
`define DUTY_LSB_LO      4
`define TSEL_HI          1
`define TSEL_LO          0
`define TCTL_PSC_HI      1
`define TCTL_PSC_LO      0
`define TCTL_RUN         2
`define TCTL_CTRL_MASK   8'h7F
`define PWM_MODE_KEY     2'b11

// reset values
`define RST_MODE_CTRL    8'h00
`define RST_TIMER_SEL    8'h00
`define RST_DUTY         8'h00
`define RST_PIN_DIR      1'b1
`define RST_LIMIT        8'hFF
`define RST_TCTL         8'h00
`define RST_COUNT        8'h00

// prescaler end counts: 4 clock phases times the prescale factor, less one
`define PSC_TOP_1        6'h03
`define PSC_TOP_4        6'h0F
`define PSC_TOP_16       6'h3F

`endif

// ===== verilog/pwm_pkg.sv
// types shared by the pwm generator and its period timers
package pwm_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		PSC_DIV1  = 2'b00,
		PSC_DIV4  = 2'b01,
		PSC_DIV16 = 2'b10,
		PSC_DIVX  = 2'b11
	} prescale_t;

	typedef enum logic [1:0] {
		TSEL_T0 = 2'b00,
		TSEL_T1 = 2'b01,
		TSEL_T2 = 2'b10,
		TSEL_RS = 2'b11
	} timer_choice_t;

endpackage : pwm_pkg

// ===== verilog/timer_if.sv
// link between the generator's register file and one period timer
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
	import pwm_pkg::*;
	byte_t     limit;
	logic      run;
	prescale_t psc;
	logic      cnt_we;
	byte_t     cnt_wd;
	byte_t     count;
	logic [1:0] sub;
	logic      wrap;

	modport tmr (input limit, run, psc, cnt_we, cnt_wd,
		output count, sub, wrap);
	modport ctl (output limit, run, psc, cnt_we, cnt_wd,
		input count, sub, wrap);
endinterface : timer_if
`default_nettype wire

// ===== verilog/period_timer.sv
// one 8-bit period timer with clock-phase counter and prescaler
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module period_timer
	import pwm_pkg::*;
(
	input  wire logic i_sys_clk, // system clock
	input  wire logic i_sys_rst, // synchronous reset, high
	input  wire logic i_ce,      // clock enable, low freezes
	timer_if.tmr      bus        // control in, count out
);
	logic [5:0] psc_r;
	byte_t      count_r;
	logic [5:0] psc_top;
	logic       step;

	// four phases per timer tick, times prescale
	assign psc_top = (bus.psc == PSC_DIV1) ? `PSC_TOP_1 :
		(bus.psc == PSC_DIV4) ? `PSC_TOP_4 : `PSC_TOP_16;
	assign step = i_ce && bus.run && (psc_r == psc_top);
	// wrap marks the increment that clears the count
	assign bus.wrap  = step && (count_r == bus.limit);
	assign bus.count = count_r;
	// low time-base bits: clock phase at 1:1, else prescaler top
	assign bus.sub = (bus.psc == PSC_DIV1) ? psc_r[1:0] :
		(bus.psc == PSC_DIV4) ? psc_r[3:2] : psc_r[5:4];

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			psc_r   <= 6'h00;
			count_r <= `RST_COUNT;
		end else if (i_ce) begin
			if (bus.cnt_we) begin
				count_r <= bus.cnt_wd;
				psc_r   <= 6'h00;
			end else if (bus.run) begin
				psc_r <= step ? 6'h00 : psc_r + 6'h01;
				if (bus.wrap)
					count_r <= `RST_COUNT;
				else if (step)
					count_r <= count_r + 8'h01;
			end
		end
	end
endmodule : period_timer
`default_nettype wire

// ===== verilog/standard_pwm_generator.sv
// standard single-output pwm generator with three period timers
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module standard_pwm_generator
	import pwm_pkg::*;
#(
	parameter int N_TIMERS = 3       // selectable period timers
)(
	input  wire logic       i_sys_clk,  // system clock, 50 MHz
	input  wire logic       i_sys_rst,  // synchronous reset, high
	input  wire logic       i_ce,       // clock enable, low = sleep
	input  wire logic [7:0] i_addr,     // register byte address
	input  wire logic [7:0] i_wr_data,  // write data
	input  wire logic       i_wr_en,    // write strobe
	input  wire logic       i_rd_en,    // read strobe
	output logic      [7:0] o_rd_data,  // read data, cycle after strobe
	output logic            o_pwm_out,  // pwm output pin level
	output logic            o_pwm_oe    // pwm pin output enable
);
	// ---------------- registers ----------------
	byte_t      mode_r;      // pwm_mode_control
	byte_t      tsel_r;      // pwm_timer_select
	byte_t      duty_high_r; // duty_high_bits
	byte_t      duty_buf_r;  // duty_buffer
	logic [1:0] lat_r;       // hidden duty low-bit latch
	logic       dir_r;       // pin_direction_bit, 1 = input
	logic       out_r;
	logic       oe_r;
	logic       start_r;     // first cycle of a new period
	byte_t      rd_r;

	byte_t      limit_r [N_TIMERS];
	byte_t      tctl_r  [N_TIMERS];
	logic       flag_r  [N_TIMERS];

	// ---------------- decode ----------------
	wire logic       hit_mode  = (i_addr == `OFS_MODE_CTRL);
	wire logic       hit_tsel  = (i_addr == `OFS_TIMER_SEL);
	wire logic       hit_dhigh = (i_addr == `OFS_DUTY_HIGH);
	wire logic       hit_dbuf  = (i_addr == `OFS_DUTY_BUF);
	wire logic       hit_dir   = (i_addr == `OFS_PIN_DIR);
	wire logic       hit_tmr   = (i_addr[7:4] == `TMR_BASE_HI);
	wire logic [1:0] tmr_num   = i_addr[3:2];
	wire logic [1:0] tmr_idx   = i_addr[1:0];

	wire logic wr = i_wr_en && i_ce;
	wire logic rd = i_rd_en && i_ce;

	// pwm mode lives in the upper pair of the mode field
	wire logic pwm_mode =
		(mode_r[`MODE_FIELD_HI:`MODE_FIELD_HI-1] == `PWM_MODE_KEY);

	// ---------------- timers ----------------
	timer_if tif [N_TIMERS] ();

	logic [N_TIMERS-1:0] wrap_v;
	byte_t               cnt_v [N_TIMERS];
	logic [1:0]          sub_v [N_TIMERS];
	logic [N_TIMERS-1:0] thit_v;

	genvar g;
	generate
		for (g = 0; g < N_TIMERS; g++) begin : g_tmr
			assign thit_v[g] = hit_tmr && (tmr_num == 2'(g));
			assign tif[g].limit  = limit_r[g];
			assign tif[g].run    = tctl_r[g][`TCTL_RUN];
			// postscale bits are stored but never reach the timer
			assign tif[g].psc    =
				prescale_t'(tctl_r[g][`TCTL_PSC_HI:`TCTL_PSC_LO]);
			assign tif[g].cnt_we = wr && thit_v[g] &&
				(tmr_idx == `TMR_IDX_COUNT);
			assign tif[g].cnt_wd = i_wr_data;
			assign wrap_v[g]     = tif[g].wrap;
			assign cnt_v[g]      = tif[g].count;
			assign sub_v[g]      = tif[g].sub;

			period_timer u_tmr (
				.i_sys_clk (i_sys_clk),
				.i_sys_rst (i_sys_rst),
				.i_ce      (i_ce),
				.bus       (tif[g].tmr)
			);

			wire logic wr_lim  = wr && thit_v[g] &&
				(tmr_idx == `TMR_IDX_LIMIT);
			wire logic wr_ctl  = wr && thit_v[g] &&
				(tmr_idx == `TMR_IDX_CTRL);
			wire logic wr_flag = wr && thit_v[g] &&
				(tmr_idx == `TMR_IDX_FLAG);

			always_ff @(posedge i_sys_clk) begin
				if (i_sys_rst) begin
					limit_r[g] <= `RST_LIMIT;
					tctl_r[g]  <= `RST_TCTL;
					flag_r[g]  <= 1'b0;
				end else if (i_ce) begin
					if (wr_lim)
						limit_r[g] <= i_wr_data;
					if (wr_ctl)
						tctl_r[g] <= i_wr_data & `TCTL_CTRL_MASK;
					// a period match beats a same-cycle software clear
					if (wrap_v[g])
						flag_r[g] <= 1'b1;
					else if (wr_flag)
						flag_r[g] <= i_wr_data[0];
				end
			end
		end
	endgenerate

	// ---------------- timer selection ----------------
	// the reserved code falls back to the first timer
	wire timer_choice_t tchoice =
		timer_choice_t'(tsel_r[`TSEL_HI:`TSEL_LO]);
	wire logic [1:0] sel = (tchoice == TSEL_RS) ? 2'h0 : tchoice;

	wire logic       sel_wrap = wrap_v[sel];
	// ten-bit time base: count on top, two sub bits below
	wire logic [9:0] tbase    = {cnt_v[sel], sub_v[sel]};

	// ---------------- duty path ----------------
	wire logic [1:0] duty_lsb = mode_r[`DUTY_LSB_HI:`DUTY_LSB_LO];
	wire logic [9:0] duty_new = {duty_high_r, duty_lsb};
	wire logic [9:0] duty_cur = {duty_buf_r, lat_r};
	// with a short period the upper duty values are never reached,
	// which is why resolution shrinks below a limit of 255
	wire logic       cmp_hit  = (tbase == duty_cur);
	wire logic       load_buf = pwm_mode && sel_wrap;

	// the set is taken on the first cycle of the period, like the clear
	// on the first cycle of the matching step, so both lag by one clock
	// and the high time is exactly duty steps; set wins a same-cycle hit
	wire logic out_nxt =
		!pwm_mode ? 1'b0 :
		start_r   ? (duty_cur != 10'h000) :
		cmp_hit   ? 1'b0 :
		out_r;
	// the pin is driven only in pwm mode with its direction bit low
	wire logic oe_nxt = pwm_mode && !dir_r;

	// ---------------- read selection ----------------
	wire byte_t tmr_rd_limit = limit_r[tmr_num];
	wire byte_t tmr_rd_ctl   = tctl_r[tmr_num];
	wire byte_t tmr_rd_cnt   = cnt_v[tmr_num];
	wire byte_t tmr_rd_flag  = {7'h00, flag_r[tmr_num]};
	wire logic  tmr_ok       = hit_tmr && (tmr_num < 2'(N_TIMERS));

	wire byte_t tmr_rd =
		(tmr_idx == `TMR_IDX_LIMIT) ? tmr_rd_limit :
		(tmr_idx == `TMR_IDX_CTRL)  ? tmr_rd_ctl   :
		(tmr_idx == `TMR_IDX_COUNT) ? tmr_rd_cnt   : tmr_rd_flag;

	// unmapped addresses read as zero
	wire byte_t rd_val =
		hit_mode  ? mode_r      :
		hit_tsel  ? tsel_r      :
		hit_dhigh ? duty_high_r :
		hit_dbuf  ? duty_buf_r  :
		hit_dir   ? {7'h00, dir_r} :
		tmr_ok    ? tmr_rd      : 8'h00;

	// ---------------- block registers ----------------
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mode_r      <= `RST_MODE_CTRL;
			tsel_r      <= `RST_TIMER_SEL;
			duty_high_r <= `RST_DUTY;
			dir_r       <= `RST_PIN_DIR;
		end else if (i_ce) begin
			// duty writes land at any time; the buffer isolates them
			if (wr && hit_mode)
				mode_r <= i_wr_data;
			if (wr && hit_tsel)
				tsel_r <= i_wr_data;
			if (wr && hit_dhigh)
				duty_high_r <= i_wr_data;
			if (wr && hit_dir)
				dir_r <= i_wr_data[0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			duty_buf_r <= `RST_DUTY;
			lat_r      <= 2'b00;
		end else if (i_ce) begin
			if (load_buf) begin
				duty_buf_r <= duty_high_r;
				lat_r      <= duty_lsb;
			end else if (wr && hit_dbuf && !pwm_mode) begin
				// software may only touch the buffer outside pwm mode
				duty_buf_r <= i_wr_data;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			out_r   <= 1'b0;
			oe_r    <= 1'b0;
			start_r <= 1'b0;
		end else if (i_ce) begin
			out_r   <= out_nxt;
			oe_r    <= oe_nxt;
			start_r <= sel_wrap;
		end
	end

	// read data stands one cycle, zero otherwise
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst)
			rd_r <= 8'h00;
		else
			rd_r <= rd ? rd_val : 8'h00;
	end

	assign o_rd_data = rd_r;
	assign o_pwm_out = out_r;
	assign o_pwm_oe  = oe_r;

endmodule : standard_pwm_generator
`default_nettype wire

// ===== sim/pwm_load.sv
// load on the pwm pin: measures cycles between rising edges
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
	input  wire logic        i_clk,     // system clock
	input  wire logic        i_level,   // pin level
	input  wire logic        i_oe,      // pin is driven
	output logic      [15:0] o_per_len  // last rise-to-rise length
);
	logic [15:0] cnt_r = 16'h0000;
	logic        prev_r = 1'b0;
	// an undriven pin is pulled low, so no edges are seen
	logic        pin;
	assign pin = i_oe & i_level;
	always_ff @(posedge i_clk) begin
		prev_r <= pin;
		cnt_r <= (pin && !prev_r) ? 16'h0001 : cnt_r + 16'h0001;
		if (pin && !prev_r)
			o_per_len <= cnt_r;
	end
endmodule : pwm_load
`default_nettype wire

// ===== sim/standard_pwm_generator_asserts.sv
// port-level assertions for the pwm generator
`timescale 1ns/1ps
`default_nettype none
module standard_pwm_generator_asserts (
	input wire logic       i_sys_clk, // system clock
	input wire logic       i_sys_rst, // synchronous reset
	input wire logic       i_ce,      // clock enable
	input wire logic [7:0] i_addr,    // register address
	input wire logic [7:0] i_wr_data, // write data
	input wire logic       i_wr_en,   // write strobe
	input wire logic       i_rd_en,   // read strobe
	input wire logic [7:0] o_rd_data, // read data
	input wire logic       o_pwm_out, // pwm level
	input wire logic       o_pwm_oe   // pin enable
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	wire acc = i_rd_en && i_ce;
	sequence s_mode_zero;
		i_ce && i_wr_en && i_addr == 8'h00 && i_wr_data == 8'h00 ##1 i_ce;
	endsequence
	sequence s_pin_off;
		##1 (!o_pwm_oe && !o_pwm_out);
	endsequence
	chk_reset_pin_off: assert property (disable iff (1'b0)
		i_sys_rst |=> !o_pwm_oe && !o_pwm_out && o_rd_data == 8'h00)
		else $error("outputs active after reset");
	chk_read_idle: assert property (!acc |=> o_rd_data == 8'h00)
		else $error("read data without a taken read");
	chk_sleep_hold: assert property (!i_ce |=>
		$stable(o_pwm_out) && $stable(o_pwm_oe))
		else $error("pin changed while asleep");
	chk_mode_release: assert property (s_mode_zero |-> s_pin_off)
		else $error("pin still driven after mode clear");
	chk_dir_release: assert property (i_ce && i_wr_en &&
		i_addr == 8'h04 && i_wr_data[0] ##1 i_ce |-> ##1 !o_pwm_oe)
		else $error("pin driven with direction set to input");
	chk_unmapped_zero: assert property (acc &&
		(i_addr inside {[8'h05:8'h0F]} || i_addr > 8'h1B)
		|=> o_rd_data == 8'h00)
		else $error("unmapped read not zero");
	chk_ctl_top_bit: assert property (acc && i_addr[7:4] == 4'h1 &&
		i_addr[1:0] == 2'h1 |=> !o_rd_data[7])
		else $error("timer control bit 7 not zero");
	chk_flag_bits: assert property (acc && i_addr[7:4] == 4'h1 &&
		i_addr[1:0] == 2'h3 |=> o_rd_data[7:1] == 7'h00)
		else $error("flag register upper bits not zero");
endmodule : standard_pwm_generator_asserts
bind standard_pwm_generator standard_pwm_generator_asserts u_chk (
	.i_sys_clk, .i_sys_rst, .i_ce, .i_addr, .i_wr_data, .i_wr_en,
	.i_rd_en, .o_rd_data, .o_pwm_out, .o_pwm_oe);
`default_nettype wire

// ===== sim/standard_pwm_generator_bench.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
`default_nettype none
module standard_pwm_generator_bench;
	import pwm_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_ce = 1'b1;
	byte_t       i_addr = 8'h00;
	byte_t       i_wr_data = 8'h00;
	logic        i_wr_en = 1'b0;
	logic        i_rd_en = 1'b0;
	byte_t       o_rd_data;
	logic        o_pwm_out;
	logic        o_pwm_oe;
	logic [15:0] per_len;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	standard_pwm_generator i_dut (.i_sys_clk, .i_sys_rst, .i_ce, .i_addr,
		.i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_pwm_out, .o_pwm_oe);
	pwm_load i_load (.i_clk(i_sys_clk), .i_level(o_pwm_out),
		.i_oe(o_pwm_oe), .o_per_len(per_len));
	initial begin
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	task automatic end_of_test;
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// longest run is near 13000 cycles
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_sys_clk);
		i_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input byte_t a, output byte_t v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_en <= 1'b0;
		@(negedge i_sys_clk);
		v = o_rd_data;
	endtask : rd
	task automatic chk(input byte_t a, input byte_t e);
		byte_t v;
		rd(a, v);
		cmp({8'h00, v}, {8'h00, e});
	endtask : chk
	function automatic int exp_high(int d, int psc, int p);
		return (d * psc >= p) ? p : d * psc;
	endfunction : exp_high
	initial begin
		byte_t v;
		byte_t t;
		int k, lim, psc, pcode, d, p, h, n;
		k = $urandom(62);
		repeat (5) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		chk(8'h00, 8'h00);
		chk(8'h04, 8'h01);
		chk(8'h07, 8'h00);
		for (k = 0; k < 3; k++) begin
			chk(8'h10 + 8'(4 * k), 8'hFF);
			chk(8'h11 + 8'(4 * k), 8'h00);
		end
		// first three passes: zero duty, duty past period, shortest period
		for (n = 0; n < 9; n++) begin
			k = $urandom_range(2);
			t = 8'h10 + 8'(4 * k);
			pcode = (n == 2) ? 0 : $urandom_range(2);
			psc = 1 << (2 * pcode);
			lim = (n == 2) ? 0 : $urandom_range(7);
			p = (lim + 1) * 4 * psc;
			d = (n == 0) ? 0 : (n == 1) ? 4 * lim + 5 :
				(n == 2) ? 2 : $urandom_range(4 * lim + 3, 1);
			wr(8'h04, 8'h01);
			wr(t + 8'h01, 8'h00);
			wr(t + 8'h02, 8'h00);
			wr(t, 8'(lim));
			wr(8'h00, 8'h0C | (8'(d[1:0]) << 4));
			wr(8'h02, 8'(d >> 2));
			wr(8'h01, 8'(k));
			wr(t + 8'h03, 8'h00);
			v = {1'b0, 4'($urandom), 1'b1, 2'(pcode)};
			wr(t + 8'h01, v);
			chk(t + 8'h01, v);
			h = 0;
			v = 8'h00;
			while (v[0] !== 1'b1 && h < 600) begin
				rd(t + 8'h03, v);
				h++;
			end
			cmp({15'h0, v[0]}, 16'h0001);
			chk(8'h03, 8'(d >> 2));
			wr(8'h03, 8'h5A);
			chk(8'h03, 8'(d >> 2));
			wr(8'h04, 8'h00);
			i_ce <= 1'b0;
			repeat (7) @(posedge i_sys_clk);
			i_ce <= 1'b1;
			repeat (2) begin
				h = 0;
				repeat (p) begin
					@(negedge i_sys_clk);
					h += int'(o_pwm_out === 1'b1);
				end
				cmp(16'(h), 16'(exp_high(d, psc, p)));
			end
			// the load sees a rise one clock late
			@(negedge i_sys_clk);
			if (d > 0 && d < 4 * lim + 4)
				cmp(per_len, 16'(p));
			cmp({15'h0, o_pwm_oe}, 16'h0001);
		end
		wr(8'h00, 8'h00);
		repeat (2) @(negedge i_sys_clk);
		cmp({14'h0, o_pwm_oe, o_pwm_out}, 16'h0000);
		wr(8'h04, 8'h01);
		@(posedge i_sys_clk);
		i_ce <= 1'b0;
		chk(8'h04, 8'h00);
		@(posedge i_sys_clk);
		i_ce <= 1'b1;
		chk(8'h04, 8'h01);
		end_of_test();
	end
endmodule : standard_pwm_generator_bench
`default_nettype wire
